// File: hw/adcc_pkg.sv
// Package: register map, field layout, reset values and sequencing constants
package adcc_pkg;
   // Register byte offsets on the APB
   localparam logic [11:0] ADCC_OFS_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] ADCC_OFS_RESULT = 12'h004;
   localparam logic [11:0] ADCC_OFS_CLOCK_SELECT = 12'h008;

   // Status and control field positions
   localparam int ADCC_BIT_DONE = 7;
   localparam int ADCC_BIT_IRQ_EN = 6;
   localparam int ADCC_BIT_CONT = 5;
   localparam int ADCC_CH_MSB = 4;
   localparam int ADCC_CH_LSB = 0;

   // Clock select field positions
   localparam int ADCC_DIV_MSB = 7;
   localparam int ADCC_DIV_LSB = 5;
   localparam int ADCC_BIT_SRC = 4;

   // Reset values
   localparam logic [4:0] ADCC_CH_RESET = 5'h1F;
   localparam logic [2:0] ADCC_DIV_RESET = 3'h0;
   localparam logic ADCC_SRC_RESET = 1'b0;

   // Channel codes
   localparam logic [4:0] ADCC_CH_POWER_OFF = 5'h1F;
   localparam logic [4:0] ADCC_CH_HIGH_REF = 5'h1D;
   localparam logic [4:0] ADCC_CH_LOW_REF = 5'h1E;
   localparam logic [4:0] ADCC_CH_LAST_PIN = 5'h0E;

   // Clock source codes
   localparam logic ADCC_SRC_BUS = 1'b1;
   localparam logic ADCC_SRC_CRYSTAL = 1'b0;

   // Prescaler terminal counts (divide ratio minus one)
   localparam logic [3:0] ADCC_TC_DIV1 = 4'h0;
   localparam logic [3:0] ADCC_TC_DIV2 = 4'h1;
   localparam logic [3:0] ADCC_TC_DIV4 = 4'h3;
   localparam logic [3:0] ADCC_TC_DIV8 = 4'h7;
   localparam logic [3:0] ADCC_TC_DIV16 = 4'hF;

   // Conversion sequencing, in converter clock ticks
   localparam logic [2:0] ADCC_SAMPLE_LAST = 3'h7;
   localparam logic [2:0] ADCC_BIT_TOP = 3'h7;
   localparam logic [7:0] ADCC_TRIAL_FIRST = 8'h80;

   // Converter sequencer states
   typedef enum logic [1:0] {
      ADCC_IDLE,
      ADCC_SAMPLE,
      ADCC_DECIDE
   } adcc_state_t;
endpackage

// File: hw/adcc_conv_if.sv
// Interface: converter clock and sequencer signals between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface adcc_conv_if;
   logic src_en;
   logic [2:0] div_code;
   logic tick;
   logic start;
   logic abort;
   logic comp;
   logic busy;
   logic done;
   logic [7:0] result;
   logic [7:0] trial;
   modport ctrl (output src_en, div_code, start, abort, comp,
                 input tick, busy, done, result, trial);
   modport presc (input src_en, div_code, output tick);
   modport sar (input tick, start, abort, comp, output busy, done, result, trial);
endinterface
`default_nettype wire

// File: hw/adcc_prescaler.sv
// Prescaler: divides the selected source enable into the converter clock tick
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Converter clock signals
   adcc_conv_if.presc cv
);
   import adcc_pkg::*;

   logic [3:0] count;
   logic [3:0] term;

   always_comb begin
      case (cv.div_code)
         3'h0: term = ADCC_TC_DIV1;
         3'h1: term = ADCC_TC_DIV2;
         3'h2: term = ADCC_TC_DIV4;
         3'h3: term = ADCC_TC_DIV8;
         default: term = ADCC_TC_DIV16;
      endcase
   end

   // Counts source enables, one tick per full ratio
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= 4'h0;
         cv.tick <= 1'b0;
      end else if (cv.src_en) begin
         if (count >= term) begin
            count <= 4'h0;
            cv.tick <= 1'b1;
         end else begin
            count <= count + 4'h1;
            cv.tick <= 1'b0;
         end
      end else begin
         cv.tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: hw/adcc_sar.sv
// Successive-approximation sequencer: sample phase, then eight bit decisions
`timescale 1ns/1ps
`default_nettype none
module adcc_sar (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Sequencer signals
   adcc_conv_if.sar cv
);
   import adcc_pkg::*;

   adcc_state_t state;
   logic [2:0] count;
   logic [7:0] keep;

   assign cv.busy = (state != ADCC_IDLE);

   // Comparator is judged one tick after each trial is set, so the
   // synchronised comparator must settle within one converter clock
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ADCC_IDLE;
         count <= 3'h0;
         cv.trial <= 8'h00;
         cv.done <= 1'b0;
      end else begin
         cv.done <= 1'b0;
         if (cv.abort) begin
            state <= ADCC_IDLE;
            cv.trial <= 8'h00;
         end else if (cv.start) begin
            state <= ADCC_SAMPLE;
            count <= 3'h0;
            cv.trial <= 8'h00;
         end else if (cv.tick) begin
            case (state)
               ADCC_SAMPLE: begin
                  if (count == ADCC_SAMPLE_LAST) begin
                     state <= ADCC_DECIDE;
                     count <= ADCC_BIT_TOP;
                     cv.trial <= ADCC_TRIAL_FIRST;
                  end else begin
                     count <= count + 3'h1;
                  end
               end
               ADCC_DECIDE: begin
                  if (count == 3'h0) begin
                     state <= ADCC_IDLE;
                     cv.done <= 1'b1;
                     cv.trial <= keep;
                  end else begin
                     count <= count - 3'h1;
                     cv.trial <= keep | (ADCC_TRIAL_FIRST >> (ADCC_BIT_TOP - count + 3'h1));
                  end
               end
               default: state <= ADCC_IDLE;
            endcase
         end
      end
   end

   always_comb begin
      keep = cv.trial;
      keep[count] = cv.comp;
   end

   // Result updates on every completion, read or not
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cv.result <= 8'h00;
      end else if (cv.tick && !cv.abort && !cv.start && state == ADCC_DECIDE
                   && count == 3'h0) begin
         cv.result <= keep;
      end
   end
endmodule
`default_nettype wire

// File: hw/adcc_top.sv
// Converter control top: APB registers, clock selection, start and flag logic
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System
   input wire logic stop_mode,
   input wire logic crystal_clock,
   // Analog front end
   input wire logic comp_in,
   output logic [4:0] analog_channel,
   output logic analog_power_on,
   output logic high_reference_sel,
   output logic low_reference_sel,
   output logic sample_hold,
   output logic [7:0] dac_code,
   // Interrupt request
   output logic conv_irq
);
   import adcc_pkg::*;

   adcc_conv_if cv ();

   adcc_prescaler adcc_prescaler_inst (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .cv(cv.presc)
   );

   adcc_sar adcc_sar_inst (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .cv(cv.sar)
   );

   // Software state
   logic irq_enable;
   logic continuous;
   logic [4:0] channel_select;
   logic [2:0] clock_prescaler;
   logic clock_source_select;
   logic conversion_done_flag;
   logic irq_pending;

   // Synchronisers and sequencing state
   logic xtal_s1;
   logic xtal_s2;
   logic xtal_s3;
   logic comp_s1;
   logic comp_s2;
   logic stop_d;
   logic resume_pending;
   logic start_q;
   logic abort_q;

   // Bus decode
   logic access;
   logic hit_sc;
   logic hit_res;
   logic hit_clk;
   logic wr_sc;
   logic wr_clk;
   logic rd_res;
   logic powered;
   logic wr_power_off;
   logic irq_drop;
   logic [31:0] next_prdata;

   assign hit_sc = (paddr == ADCC_OFS_STATUS_CONTROL);
   assign hit_res = (paddr == ADCC_OFS_RESULT);
   assign hit_clk = (paddr == ADCC_OFS_CLOCK_SELECT);
   // Completion edge of an access; side effects happen here only
   assign access = psel && penable && pready;
   assign wr_sc = access && pwrite && hit_sc;
   assign wr_clk = access && pwrite && hit_clk;
   assign rd_res = access && !pwrite && hit_res;
   assign powered = (channel_select != ADCC_CH_POWER_OFF);
   assign wr_power_off = (pwdata[ADCC_CH_MSB:ADCC_CH_LSB] == ADCC_CH_POWER_OFF);
   // A completion in the same cycle keeps the request raised
   assign irq_drop = wr_sc || rd_res;

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_sc) begin
         next_prdata[ADCC_BIT_DONE] = conversion_done_flag;
         next_prdata[ADCC_BIT_IRQ_EN] = irq_enable;
         next_prdata[ADCC_BIT_CONT] = continuous;
         next_prdata[ADCC_CH_MSB:ADCC_CH_LSB] = channel_select;
      end else if (hit_res) begin
         next_prdata[7:0] = cv.result;
      end else if (hit_clk) begin
         next_prdata[ADCC_DIV_MSB:ADCC_DIV_LSB] = clock_prescaler;
         next_prdata[ADCC_BIT_SRC] = clock_source_select;
      end
   end

   // One wait-free access phase: data and ready prepared in the setup cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= !(hit_sc || hit_res || hit_clk);
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Status and control fields
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_enable <= 1'b0;
         continuous <= 1'b0;
         channel_select <= ADCC_CH_RESET;
      end else if (wr_sc) begin
         irq_enable <= pwdata[ADCC_BIT_IRQ_EN];
         continuous <= pwdata[ADCC_BIT_CONT];
         channel_select <= pwdata[ADCC_CH_MSB:ADCC_CH_LSB];
      end
   end

   // Clock select fields
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clock_prescaler <= ADCC_DIV_RESET;
         clock_source_select <= ADCC_SRC_RESET;
      end else if (wr_clk) begin
         clock_prescaler <= pwdata[ADCC_DIV_MSB:ADCC_DIV_LSB];
         clock_source_select <= pwdata[ADCC_BIT_SRC];
      end
   end

   // Completion flag: a finishing conversion wins over a clearing access
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         conversion_done_flag <= 1'b0;
      end else if (cv.done) begin
         conversion_done_flag <= 1'b1;
      end else if (wr_sc) begin
         conversion_done_flag <= pwdata[ADCC_BIT_DONE] && pwdata[ADCC_BIT_IRQ_EN];
      end else if (rd_res) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // Interrupt request: set at conversion end, dropped by a status write or result read
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_pending <= 1'b0;
      end else if (cv.done) begin
         irq_pending <= 1'b1;
      end else if (irq_drop) begin
         irq_pending <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         conv_irq <= 1'b0;
      end else begin
         conv_irq <= irq_enable && (cv.done || (irq_pending && !irq_drop));
      end
   end

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         xtal_s1 <= 1'b0;
         xtal_s2 <= 1'b0;
         xtal_s3 <= 1'b0;
         comp_s1 <= 1'b0;
         comp_s2 <= 1'b0;
      end else begin
         xtal_s1 <= crystal_clock;
         xtal_s2 <= xtal_s1;
         xtal_s3 <= xtal_s2;
         comp_s1 <= comp_in;
         comp_s2 <= comp_s1;
      end
   end

   // Crystal rising edges become source enables; bus clock enables every cycle
   assign cv.src_en = (clock_source_select == ADCC_SRC_BUS) ? 1'b1
                      : (xtal_s2 && !xtal_s3);
   assign cv.div_code = clock_prescaler;
   assign cv.comp = comp_s2;

   // Stop handling: abort on entry, restart on exit if work was interrupted
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stop_d <= 1'b0;
         resume_pending <= 1'b0;
      end else begin
         stop_d <= stop_mode;
         if (stop_mode && !stop_d) begin
            resume_pending <= cv.busy || continuous;
         end else if (!stop_mode) begin
            resume_pending <= 1'b0;
         end
      end
   end

   // Abort pulse: stop entry, or a select that is or is being written all ones
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         abort_q <= 1'b0;
      end else if (stop_mode && !stop_d) begin
         abort_q <= 1'b1;
      end else if (wr_sc) begin
         abort_q <= wr_power_off;
      end else begin
         abort_q <= !powered;
      end
   end

   // Start pulse; a write judges the new select, the old one may still read off
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         start_q <= 1'b0;
      end else if (stop_mode) begin
         start_q <= 1'b0;
      end else if (wr_sc) begin
         start_q <= !wr_power_off;
      end else if (!powered) begin
         start_q <= 1'b0;
      end else if (cv.done && continuous) begin
         start_q <= 1'b1;
      end else if (stop_d && resume_pending) begin
         start_q <= 1'b1;
      end else begin
         start_q <= 1'b0;
      end
   end

   assign cv.start = start_q;
   assign cv.abort = abort_q;

   // Multiplexer and power controls follow the select register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         analog_channel <= ADCC_CH_RESET;
         analog_power_on <= 1'b0;
         high_reference_sel <= 1'b0;
         low_reference_sel <= 1'b0;
      end else begin
         // Unused and reserved codes pass through; the mux leaves them open
         analog_channel <= channel_select;
         analog_power_on <= powered && !stop_mode;
         high_reference_sel <= (channel_select == ADCC_CH_HIGH_REF);
         low_reference_sel <= (channel_select == ADCC_CH_LOW_REF);
      end
   end

   // Sample switch and trial word follow the sequencer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sample_hold <= 1'b0;
         dac_code <= 8'h00;
      end else begin
         sample_hold <= cv.busy && (cv.trial == 8'h00);
         dac_code <= cv.trial;
      end
   end
endmodule
`default_nettype wire

// File: tb/adcc_top_monitor.sv
// Checker: port-level properties of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_top_monitor
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Converter side
   input wire logic stop_mode,
   input wire logic [4:0] analog_channel,
   input wire logic analog_power_on,
   input wire logic high_reference_sel,
   input wire logic low_reference_sel,
   input wire logic sample_hold,
   input wire logic [7:0] dac_code,
   input wire logic conv_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   AST_RD_CLR: assert property (psel && penable && pready && !pwrite &&
      paddr == ADCC_OFS_RESULT |=> ##1 !conv_irq) else $error("irq held after result read");
   // Eight quiet cycles: even at divide by one a fresh conversion needs sixteen ticks
   AST_WR_CLR: assert property (psel && penable && pready && pwrite &&
      paddr == ADCC_OFS_STATUS_CONTROL |=> ##1 !conv_irq [*8]) else $error("irq after write");
   AST_CH_COPY: assert property (psel && penable && pready && pwrite &&
      paddr == ADCC_OFS_STATUS_CONTROL |=> ##1 analog_channel == $past(pwdata[4:0], 2))
      else $error("channel not applied");
   AST_PWR_OFF: assert property (analog_channel == ADCC_CH_POWER_OFF [*2] |->
      !analog_power_on) else $error("powered with off code");
   AST_STOP: assert property (stop_mode [*4] |-> !analog_power_on && !sample_hold)
      else $error("active in stop");
   AST_HREF: assert property (analog_channel == ADCC_CH_HIGH_REF [*2] |->
      high_reference_sel && !low_reference_sel) else $error("high reference not routed");
   AST_LREF: assert property (analog_channel == ADCC_CH_LOW_REF [*2] |->
      low_reference_sel && !high_reference_sel) else $error("low reference not routed");
   AST_MSB: assert property ($fell(sample_hold) && analog_power_on && !stop_mode |->
      ##[0:2] dac_code == ADCC_TRIAL_FIRST) else $error("first trial not MSB");

   COV_IRQ: cover property ($rose(conv_irq));
   COV_STOP: cover property (stop_mode [*3]);
   COV_HREF: cover property (high_reference_sel);
endmodule
bind adcc_top adcc_top_monitor adcc_top_monitor_inst (.sys_clk(sys_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .stop_mode(stop_mode), .analog_channel(analog_channel),
   .analog_power_on(analog_power_on), .high_reference_sel(high_reference_sel),
   .low_reference_sel(low_reference_sel), .sample_hold(sample_hold),
   .dac_code(dac_code), .conv_irq(conv_irq));
`default_nettype wire

// File: tb/adcc_top_tb.sv
// Testbench: APB register access and conversion scenarios
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb;
   import adcc_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic stop_mode = 1'b0;
   logic crystal_clock = 1'b0;
   logic comp_in = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, analog_power_on, high_reference_sel, low_reference_sel;
   logic sample_hold, conv_irq;
   logic [4:0] analog_channel;
   logic [7:0] dac_code;
   logic [7:0] target = 8'h00;
   logic [1:0] xdiv = 2'h0;
   logic [31:0] r;
   logic e;
   logic [7:0] cfg [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
   int dv [7] = '{1, 2, 4, 8, 16, 16, 4};
   int n_mismatch = 0;
   int checks_done = 0;
   int n;

   adcc_top adcc_top_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_mode(stop_mode), .crystal_clock(crystal_clock),
      .comp_in(comp_in), .analog_channel(analog_channel), .analog_power_on(analog_power_on),
      .high_reference_sel(high_reference_sel), .low_reference_sel(low_reference_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .conv_irq(conv_irq));

   always #20 sys_clk = ~sys_clk;

   // Analog side: comparator against a target level, crystal at a quarter of the bus rate
   // The crystal stays far above the rate at which the bus clock must be chosen
   always @(posedge sys_clk) begin
      comp_in <= (target >= dac_code);
      xdiv <= xdiv + 2'h1;
      crystal_clock <= xdiv[1];
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 8'h00);
      chk(nm, r, x);
   endtask

   // Polls the status register; reads there leave the flag alone
   task automatic poll_done;
      int k;
      k = 0;
      do begin
         apb(1'b0, ADCC_OFS_STATUS_CONTROL, 8'h00);
         k++;
      end while (r[7] !== 1'b1 && k < 300);
   endtask

   task automatic give_verdict;
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      rd("status reset", ADCC_OFS_STATUS_CONTROL, 32'h1F);
      rd("clock reset", ADCC_OFS_CLOCK_SELECT, 32'h00);
      chk("power at reset", analog_power_on, 1'b0);
      apb(1'b1, ADCC_OFS_RESULT, 8'hAA);
      rd("result read only", ADCC_OFS_RESULT, 32'h00);
      rd("unmapped data", 12'h00C, 32'h00);
      chk("unmapped error", e, 1'b1);
      // Bus clock over sixteen is the setting nearest the intended converter rate;
      // it also leaves the synchronised comparator time to settle before each decision
      apb(1'b1, ADCC_OFS_CLOCK_SELECT, 8'h90);
      rd("clock select", ADCC_OFS_CLOCK_SELECT, 32'h90);
      // Single conversion with the interrupt off
      target <= 8'h5A;
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h03);
      repeat (2) @(posedge sys_clk);
      chk("power on", analog_power_on, 1'b1);
      // The first conversion after power-up only lets the analog side settle
      poll_done();
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h03);
      poll_done();
      chk("done flag", r, 32'h83);
      rd("result", ADCC_OFS_RESULT, 32'h5A);
      rd("flag cleared", ADCC_OFS_STATUS_CONTROL, 32'h03);
      // Interrupt path, cleared by a result read
      target <= 8'hC3;
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h43);
      n = 0;
      while (conv_irq !== 1'b1 && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      chk("irq raised", conv_irq, 1'b1);
      rd("irq result", ADCC_OFS_RESULT, 32'hC3);
      repeat (2) @(posedge sys_clk);
      chk("irq dropped", conv_irq, 1'b0);
      // Divider codes and both sources, timed in bus cycles; settings change only when idle
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, ADCC_OFS_CLOCK_SELECT, cfg[i]);
         apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h44);
         n = 0;
         while (conv_irq !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
         end
         chk("conversion time", n >= 15 * dv[i] && n <= 17 * dv[i] + 8, 1'b1);
         apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h1F);
         repeat (2) @(posedge sys_clk);
         chk("irq after write", conv_irq, 1'b0);
      end
      apb(1'b1, ADCC_OFS_CLOCK_SELECT, 8'h90);
      // Continuous mode keeps converting and tracks a new level
      target <= 8'h11;
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h23);
      poll_done();
      apb(1'b0, ADCC_OFS_RESULT, 8'h00);
      poll_done();
      rd("first result", ADCC_OFS_RESULT, 32'h11);
      target <= 8'hEE;
      poll_done();
      apb(1'b0, ADCC_OFS_RESULT, 8'h00);
      poll_done();
      rd("later result", ADCC_OFS_RESULT, 32'hEE);
      // Stop aborts, exit resumes
      stop_mode <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("stop power", analog_power_on, 1'b0);
      stop_mode <= 1'b0;
      poll_done();
      chk("resumed", r, 32'hA3);
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h0F);
      repeat (2) @(posedge sys_clk);
      chk("unused code", analog_channel, 32'h0F);
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h1D);
      repeat (2) @(posedge sys_clk);
      chk("high reference", high_reference_sel, 1'b1);
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h1E);
      repeat (2) @(posedge sys_clk);
      chk("low reference", low_reference_sel, 1'b1);
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'hC3);
      rd("flag written", ADCC_OFS_STATUS_CONTROL, 32'hC3);
      apb(1'b1, ADCC_OFS_STATUS_CONTROL, 8'h1F);
      give_verdict();
   end
endmodule
`default_nettype wire
